// ==== core/eacr_addr_serializer.sv ====
// Shifts the 48-bit station address out one bit per enable, bit 0 first.
// Captures the address when a send starts, so the caller may change it while a send runs.
`timescale 1ns/1ps
module eacr_addr_serializer (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        nrst,
   // Control
   input  wire logic        start,
   input  wire logic        bit_en,
   input  wire logic [47:0] station_address,
   // Serial output
   output logic             ser_bit,
   output logic             ser_valid,
   output logic             busy
);
   import eacr_pkg::*;

   typedef struct packed {
      eacr_ser_state_e st;
      logic [47:0]     shreg;
      logic [5:0]      cnt;
      logic            bit_q;
      logic            val_q;
   } eacr_ser_s;

   eacr_ser_s state_reg;
   eacr_ser_s state_next;

   always_comb begin
      state_next       = state_reg;
      state_next.val_q = 1'b0;
      unique case (state_reg.st)
         EACR_SER_IDLE: begin
            if (start) begin
               state_next.st    = EACR_SER_SHIFT;
               state_next.shreg = station_address;
               state_next.cnt   = 6'h00;
            end
         end
         EACR_SER_SHIFT: begin
            if (bit_en) begin
               state_next.bit_q = state_reg.shreg[0]; // RULE10
               state_next.val_q = 1'b1;
               state_next.shreg = {1'b0, state_reg.shreg[47:1]}; // RULE10
               state_next.cnt   = state_reg.cnt + 6'h01;
               if (state_reg.cnt == 6'h2F) begin
                  state_next.st = EACR_SER_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= '{st: EACR_SER_IDLE, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign ser_bit   = state_reg.bit_q;
   assign ser_valid = state_reg.val_q;
   assign busy      = (state_reg.st == EACR_SER_SHIFT);
endmodule : eacr_addr_serializer

// ==== core/eacr_defines.svh ====
// Register offsets, field positions and reset values of the station address and filter bank.
// Included by the package and the register bank; definitions only.
`ifndef EACR_DEFINES_SVH
`define EACR_DEFINES_SVH

// Word offsets on the Avalon bus; byte address is four times the index.
`define EACR_IDX_RING_LEN   4'h6
`define EACR_IDX_MCAST0     4'h8
`define EACR_IDX_MCAST1     4'h9
`define EACR_IDX_MCAST2     4'hA
`define EACR_IDX_MCAST3     4'hB
`define EACR_IDX_STADDR0    4'hC
`define EACR_IDX_STADDR1    4'hD
`define EACR_IDX_STADDR2    4'hE
`define EACR_IDX_CTRL       4'h0
`define EACR_IDX_STATUS     4'h1

// Ring length register fields.
`define EACR_TX_CODE_MSB    15
`define EACR_TX_CODE_LSB    12
`define EACR_RX_CODE_MSB    11
`define EACR_RX_CODE_LSB    8

// Control register fields.
`define EACR_CTRL_HALT      0
`define EACR_CTRL_SEND      1

// Status register fields.
`define EACR_STAT_INIT_DONE 0
`define EACR_STAT_SENDING   1

// Value shown for fields that are not yet defined.
`define EACR_UNDEF_WORD     16'h0000
`define EACR_HALT_RESET     1'b1
`define EACR_READ_LATENCY   1

`endif

// ==== core/eacr_pkg.sv ====
// Types shared by the station address and filter bank.
// Needs eacr_defines.svh on the include path.
package eacr_pkg;
   `include "eacr_defines.svh"

   // Values loaded from the initialization block in one pulse.
   typedef struct packed {
      logic        valid;
      logic [3:0]  tx_ring_len_code;
      logic [3:0]  rx_ring_len_code;
      logic [63:0] multicast_hash_filter;
      logic [47:0] station_address;
   } eacr_init_s;

   // Avalon-MM slave request side.
   typedef struct packed {
      logic [3:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } eacr_avm_req_s;

   typedef enum logic [1:0] {
      EACR_BUS_IDLE,
      EACR_BUS_ANSWER
   } eacr_bus_state_e;

   typedef enum logic [1:0] {
      EACR_SER_IDLE,
      EACR_SER_SHIFT
   } eacr_ser_state_e;

endpackage : eacr_pkg

// ==== core/eacr_regs.sv ====
// Function
// RULE1 - Ring register bits 15:12 hold transmit code
// RULE2 - Ring register bits 11:8 hold receive code
// RULE3 - Ring register readable when halted; writes ignored
// RULE4 - Ring codes defined only after initialization
// RULE5 - Ring register bits 7:0 read zero
// RULE6 - Hash filter across four words, ascending
// RULE7 - Filter/address loaded by init or host
// RULE8 - Filter/address host access only while halted
// RULE9 - Station address across three words, ascending
// RULE10 - Address sent bit 0 first, 47 last
// RULE11 - Access while running leaves contents unchanged
//
// Station address and multicast filter register bank on an Avalon-MM slave.
// Assumes a single clock; the init engine delivers all values in one pulse.
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "eacr_defines.svh"
module eacr_regs #(
   parameter int BIT_DIV = 4
) (
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       nrst,
   // Avalon-MM slave
   input  wire eacr_pkg::eacr_avm_req_s    avm_req,
   output logic      [31:0]                avm_readdata,
   output logic                            avm_waitrequest,
   // Initialization block load
   input  wire eacr_pkg::eacr_init_s       init_load,
   // Values for the receive matching logic
   output logic      [63:0]                multicast_hash_filter,
   output logic      [47:0]                station_address,
   output logic      [3:0]                 tx_ring_len_code,
   output logic      [3:0]                 rx_ring_len_code,
   output logic                            halted,
   // Serial station address
   output logic                            addr_ser_bit,
   output logic                            addr_ser_valid
);
   import eacr_pkg::*;

   localparam int WORDS = 7;

   typedef struct packed {
      eacr_bus_state_e st;
      logic            halt;
      logic            init_done;
      logic [3:0]      tx_code;
      logic [3:0]      rx_code;
      logic [15:0]     rdata;
      logic            from_store;
      logic            send;
      logic [7:0]      div;
      logic            bit_en;
   } eacr_regs_s;

   eacr_regs_s state_reg;
   eacr_regs_s state_next;

   logic [WORDS-1:0]    wr_en;
   logic [WORDS*16-1:0] wr_data;
   logic [WORDS*16-1:0] init_words;
   logic [2:0]          rd_sel;
   logic [15:0]         store_rd;
   logic [WORDS*16-1:0] words;
   logic                ser_busy;
   logic                take;
   logic                is_store;
   logic [2:0]          store_idx;
   logic                word_be;

   // Word index within the store for a bus address, and whether it is a store word.
   always_comb begin
      is_store  = 1'b0;
      store_idx = 3'h0;
      unique case (avm_req.address)
         `EACR_IDX_MCAST0:  begin is_store = 1'b1; store_idx = 3'h0; end // RULE6
         `EACR_IDX_MCAST1:  begin is_store = 1'b1; store_idx = 3'h1; end // RULE6
         `EACR_IDX_MCAST2:  begin is_store = 1'b1; store_idx = 3'h2; end // RULE6
         `EACR_IDX_MCAST3:  begin is_store = 1'b1; store_idx = 3'h3; end // RULE6
         `EACR_IDX_STADDR0: begin is_store = 1'b1; store_idx = 3'h4; end // RULE9
         `EACR_IDX_STADDR1: begin is_store = 1'b1; store_idx = 3'h5; end // RULE9
         `EACR_IDX_STADDR2: begin is_store = 1'b1; store_idx = 3'h6; end // RULE9
         default:           begin is_store = 1'b0; store_idx = 3'h0; end
      endcase
   end

   assign take    = (state_reg.st == EACR_BUS_IDLE) && (avm_req.read || avm_req.write);
   assign word_be = avm_req.byteenable[1] | avm_req.byteenable[0];
   assign rd_sel  = store_idx;

   // Init values laid out in store order, filter words first, so each word is a plain slice.
   assign init_words = {init_load.station_address, init_load.multicast_hash_filter};

   // Init load and host write share the store; the init load wins a collision
   // because it carries a whole consistent set of values.
   genvar gi;
   generate
      for (gi = 0; gi < WORDS; gi++) begin : g_wr
         logic [15:0] host_word;
         assign host_word = {
            avm_req.byteenable[1] ? avm_req.writedata[15:8] : words[gi*16+8 +: 8],
            avm_req.byteenable[0] ? avm_req.writedata[7:0]  : words[gi*16 +: 8]};
         assign wr_en[gi] = init_load.valid
                            || (take && avm_req.write && is_store && word_be
                                && (store_idx == 3'(gi)) && state_reg.halt); // RULE7 RULE8 RULE11
         assign wr_data[gi*16 +: 16] = init_load.valid ? init_words[gi*16 +: 16]
                                                       : host_word; // RULE7
      end
   endgenerate

   always_comb begin
      state_next        = state_reg;
      state_next.bit_en = 1'b0;
      state_next.send   = 1'b0;

      if (state_reg.div == 8'(BIT_DIV - 1)) begin
         state_next.div    = 8'h00;
         state_next.bit_en = 1'b1;
      end else begin
         state_next.div = state_reg.div + 8'h01;
      end

      if (init_load.valid) begin
         state_next.tx_code   = init_load.tx_ring_len_code; // RULE1
         state_next.rx_code   = init_load.rx_ring_len_code; // RULE2
         state_next.init_done = 1'b1; // RULE4
      end

      unique case (state_reg.st)
         EACR_BUS_IDLE: begin
            if (take) begin
               state_next.st         = EACR_BUS_ANSWER;
               state_next.rdata      = 16'h0000;
               state_next.from_store = 1'b0;
               if (avm_req.read) begin
                  unique case (avm_req.address)
                     `EACR_IDX_RING_LEN: begin
                        if (state_reg.halt && state_reg.init_done) begin // RULE3 RULE4
                           state_next.rdata[`EACR_TX_CODE_MSB:`EACR_TX_CODE_LSB] =
                              state_reg.tx_code; // RULE1
                           state_next.rdata[`EACR_RX_CODE_MSB:`EACR_RX_CODE_LSB] =
                              state_reg.rx_code; // RULE2
                        end
                        state_next.rdata[7:0] = 8'h00; // RULE5
                     end
                     `EACR_IDX_CTRL: begin
                        state_next.rdata[`EACR_CTRL_HALT] = state_reg.halt;
                     end
                     `EACR_IDX_STATUS: begin
                        state_next.rdata[`EACR_STAT_INIT_DONE] = state_reg.init_done;
                        state_next.rdata[`EACR_STAT_SENDING]   = ser_busy;
                     end
                     default: begin
                        state_next.from_store = is_store && state_reg.halt; // RULE8 RULE11
                     end
                  endcase
               end else if (avm_req.address == `EACR_IDX_CTRL && avm_req.byteenable[0]) begin
                  state_next.halt = avm_req.writedata[`EACR_CTRL_HALT];
                  state_next.send = avm_req.writedata[`EACR_CTRL_SEND];
               end
               // Writes to the ring length word fall through untouched. RULE3
            end
         end
         EACR_BUS_ANSWER: begin
            state_next.st = EACR_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= '{st: EACR_BUS_IDLE, halt: `EACR_HALT_RESET, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   eacr_word_store #(
      .WORDS (WORDS)
   ) u_store (
      .clock     (clock),
      .nrst      (nrst),
      .wr_en     (wr_en),
      .wr_data   (wr_data),
      .rd_sel    (rd_sel),
      .rd_data   (store_rd),
      .all_words (words)
   );

   eacr_addr_serializer u_ser (
      .clock           (clock),
      .nrst            (nrst),
      .start           (state_reg.send),
      .bit_en          (state_reg.bit_en),
      .station_address (words[111:64]),
      .ser_bit         (addr_ser_bit),
      .ser_valid       (addr_ser_valid),
      .busy            (ser_busy)
   );

   // The answer cycle is the one after the request is taken.
   assign avm_waitrequest = (avm_req.read || avm_req.write) && (state_reg.st != EACR_BUS_ANSWER);
   assign avm_readdata    = {16'h0000, state_reg.from_store ? store_rd : state_reg.rdata};

   assign multicast_hash_filter = words[63:0];
   assign station_address       = words[111:64];
   assign tx_ring_len_code      = state_reg.tx_code;
   assign rx_ring_len_code      = state_reg.rx_code;
   assign halted                = state_reg.halt;
endmodule : eacr_regs

// ==== core/eacr_word_store.sv ====
// Holds the seven 16-bit filter and address words with a registered read port.
// Assumes one writer; the owner arbitrates between init load and host write.
`timescale 1ns/1ps
module eacr_word_store #(
   parameter int WORDS = 7
) (
   // Clock and reset
   input  wire logic                     clock,
   input  wire logic                     nrst,
   // Write port
   input  wire logic [WORDS-1:0]         wr_en,
   input  wire logic [WORDS*16-1:0]      wr_data,
   // Read port
   input  wire logic [2:0]               rd_sel,
   output logic      [15:0]              rd_data,
   output logic      [WORDS*16-1:0]      all_words
);
   import eacr_pkg::*;

   typedef struct packed {
      logic [WORDS*16-1:0] words;
      logic [15:0]         rd;
   } eacr_store_s;

   eacr_store_s state_reg;
   eacr_store_s state_next;

   always_comb begin
      state_next = state_reg;
      for (int i = 0; i < WORDS; i++) begin
         if (wr_en[i]) begin
            state_next.words[i*16 +: 16] = wr_data[i*16 +: 16];
         end
      end
      state_next.rd = (int'(rd_sel) < WORDS) ? state_reg.words[rd_sel*16 +: 16] : 16'h0000;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rd_data   = state_reg.rd;
   assign all_words = state_reg.words;
endmodule : eacr_word_store

// ==== tb/eacr_regs_monitor.sv ====
// Checker for the register bank: bus handshake, store contents and serial pulses.
// Bound to eacr_regs and sees only its ports.
`timescale 1ns/1ps
module eacr_regs_monitor #(
   parameter int BIT_DIV = 4
) (
   // Clock and reset
   input wire logic                    clock,
   input wire logic                    nrst,
   // Register bus
   input wire eacr_pkg::eacr_avm_req_s avm_req,
   input wire logic [31:0]             avm_readdata,
   input wire logic                    avm_waitrequest,
   // Init load and stored values
   input wire eacr_pkg::eacr_init_s    init_load,
   input wire logic [63:0]             multicast_hash_filter,
   input wire logic [47:0]             station_address,
   input wire logic [3:0]              tx_ring_len_code,
   input wire logic [3:0]              rx_ring_len_code,
   input wire logic                    halted,
   input wire logic                    addr_ser_bit,
   input wire logic                    addr_ser_valid
);
   import eacr_pkg::*;
   logic         seen_init_reg;
   logic [111:0] all_w;
   logic         req;
   logic         st;
   logic         rd;
   assign all_w = {station_address, multicast_hash_filter};
   assign req = avm_req.read | avm_req.write;
   assign rd = avm_req.read;
   assign st = (avm_req.address >= 4'h8) && (avm_req.address <= 4'hE);
   function automatic logic [15:0] word_at(input logic [111:0] v, input logic [3:0] a);
      return v[(int'(a) - 8) * 16 +: 16];
   endfunction : word_at
   // Ring codes only mean something once an init load has been seen.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         seen_init_reg <= 1'b0;
      end else if (init_load.valid) begin
         seen_init_reg <= 1'b1;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence s_taken;
      req && avm_waitrequest;
   endsequence
   sequence s_answer;
      req && !avm_waitrequest;
   endsequence
   a_one_wait: assert property (s_taken |=> !avm_waitrequest)
      else $error("request not answered after one wait cycle");
   a_next_waits: assert property (s_answer ##1 req |-> avm_waitrequest)
      else $error("back to back request answered without wait");
   a_ring_low: assert property (s_answer and rd && avm_req.address == 4'h6 |->
      avm_readdata[7:0] == 8'h00)
      else $error("ring word low byte not zero");
   a_ring_codes: assert property (s_answer and rd && avm_req.address == 4'h6 && halted
      && seen_init_reg |-> avm_readdata[15:8] == {tx_ring_len_code, rx_ring_len_code})
      else $error("ring word fields wrong");
   a_ring_fixed: assert property (!init_load.valid |=>
      $stable({tx_ring_len_code, rx_ring_len_code}))
      else $error("ring codes changed without init");
   a_init_loads: assert property (init_load.valid |=> {tx_ring_len_code, rx_ring_len_code,
      all_w} == $past({init_load.tx_ring_len_code, init_load.rx_ring_len_code,
      init_load.station_address, init_load.multicast_hash_filter}))
      else $error("init load not taken");
   a_store_read: assert property (s_answer and rd && halted && st |->
      avm_readdata[15:0] == word_at(all_w, avm_req.address))
      else $error("store word read wrong");
   a_store_write: assert property (s_answer and avm_req.write && halted && st &&
      avm_req.byteenable == 4'hF && !init_load.valid && !$past(init_load.valid) |=>
      word_at(all_w, $past(avm_req.address)) == $past(avm_req.writedata[15:0]))
      else $error("store word write lost");
   a_run_hold: assert property (!halted && !init_load.valid |=> $stable(all_w))
      else $error("store changed while running");
   a_run_zero: assert property (s_answer and rd && !halted &&
      (st || avm_req.address == 4'h6) |-> avm_readdata == 32'h0000_0000)
      else $error("read while running not zero");
   a_ser_gap: assert property (addr_ser_valid && BIT_DIV > 1 |=> !addr_ser_valid)
      else $error("serial valid longer than one cycle");
endmodule : eacr_regs_monitor

bind eacr_regs eacr_regs_monitor #(.BIT_DIV(BIT_DIV)) u_eacr_regs_monitor (
   .clock(clock), .nrst(nrst), .avm_req(avm_req), .avm_readdata(avm_readdata),
   .avm_waitrequest(avm_waitrequest), .init_load(init_load),
   .multicast_hash_filter(multicast_hash_filter), .station_address(station_address),
   .tx_ring_len_code(tx_ring_len_code), .rx_ring_len_code(rx_ring_len_code),
   .halted(halted), .addr_ser_bit(addr_ser_bit), .addr_ser_valid(addr_ser_valid));

// ==== tb/eacr_regs_tb_top.sv ====
// Self-checking bench for the register bank, driven over Avalon-MM.
// Expects the package and the checker to be compiled first.
`timescale 1ns/1ps
module eacr_regs_tb_top;
   import eacr_pkg::*;
   localparam logic [3:0]  TX  = 4'hA;
   localparam logic [3:0]  RX  = 4'h5;
   localparam logic [63:0] FLT = 64'h0123_4567_89AB_CDEF;
   localparam logic [47:0] STA = 48'h1A2B_3C4D_5E6F;
   logic          clock;
   logic          nrst;
   eacr_avm_req_s avm_req;
   logic [31:0]   avm_readdata;
   logic          avm_waitrequest;
   eacr_init_s    init_load;
   logic [63:0]   multicast_hash_filter;
   logic [47:0]   station_address;
   logic [3:0]    tx_ring_len_code;
   logic [3:0]    rx_ring_len_code;
   logic          halted;
   logic          addr_ser_bit;
   logic          addr_ser_valid;
   logic [31:0]   rd;
   logic [47:0]   sta;
   int            miscompares;
   int            tests_run;
   int            k;
   int            n;
   eacr_regs #(.BIT_DIV(4)) u_eacr_regs (
      .clock(clock), .nrst(nrst), .avm_req(avm_req), .avm_readdata(avm_readdata),
      .avm_waitrequest(avm_waitrequest), .init_load(init_load),
      .multicast_hash_filter(multicast_hash_filter), .station_address(station_address),
      .tx_ring_len_code(tx_ring_len_code), .rx_ring_len_code(rx_ring_len_code),
      .halted(halted), .addr_ser_bit(addr_ser_bit), .addr_ser_valid(addr_ser_valid));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run
   // Holds the request until waitrequest is sampled low; a slave that never answers ends the run.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int cnt;
      @(posedge clock);
      avm_req.address <= a;
      avm_req.read <= !wr;
      avm_req.write <= wr;
      avm_req.writedata <= d;
      cnt = 0;
      do begin
         @(posedge clock);
         cnt++;
      end while (avm_waitrequest !== 1'b0 && cnt < 20);
      q = avm_readdata;
      avm_req.read <= 1'b0;
      avm_req.write <= 1'b0;
      if (avm_waitrequest !== 1'b0) begin
         miscompares++;
         complete_run();
      end
   endtask : bus
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, rd);
      check(rd, exp);
   endtask : rdc
   initial begin
      nrst = 1'b0;
      avm_req = '{4'h0, 1'b0, 1'b0, 32'h0000_0000, 4'hF};
      init_load = '0;
      miscompares = 0;
      tests_run = 0;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      rdc(4'h6, 32'h0000_0000);
      check(halted, 1'b1);
      rdc(4'h0, 32'h0000_0001);
      @(posedge clock);
      init_load <= '{1'b1, TX, RX, FLT, STA};
      @(posedge clock);
      init_load.valid <= 1'b0;
      rdc(4'h6, {16'h0000, TX, RX, 8'h00});
      check({tx_ring_len_code, rx_ring_len_code}, {TX, RX});
      check(multicast_hash_filter, FLT);
      rdc(4'h1, 32'h0000_0001);
      // The host keeps off the reserved low byte even in this no-effect probe.
      bus(1'b1, 4'h6, 32'h0000_5A00, rd);
      rdc(4'h6, {16'h0000, TX, RX, 8'h00});
      for (k = 0; k < 4; k++) rdc(4'(8 + k), {16'h0000, FLT[16*k +: 16]});
      for (k = 0; k < 3; k++) rdc(4'(12 + k), {16'h0000, STA[16*k +: 16]});
      sta = {STA[47:16], 16'hBEEF};
      bus(1'b1, 4'hC, 32'h0000_BEEF, rd);
      rdc(4'hC, 32'h0000_BEEF);
      check(station_address, sta);
      // Only the low byte lane is enabled, so the high byte must keep its value.
      avm_req.byteenable <= 4'h1;
      bus(1'b1, 4'hC, 32'h0000_AA55, rd);
      avm_req.byteenable <= 4'hF;
      sta[15:0] = 16'hBE55;
      rdc(4'hC, 32'h0000_BE55);
      bus(1'b1, 4'h3, 32'h0000_FFFF, rd);
      rdc(4'h3, 32'h0000_0000);
      rdc(4'hF, 32'h0000_0000);
      // Start a send while keeping the halt bit set.
      bus(1'b1, 4'h0, 32'h0000_0003, rd);
      k = 0;
      n = 0;
      while (k < 48 && n < 1000) begin
         @(posedge clock);
         n++;
         if (addr_ser_valid === 1'b1) begin
            check(addr_ser_bit, sta[k]);
            k++;
         end
      end
      check(48'(k), 48'd48);
      rdc(4'h1, 32'h0000_0001);
      bus(1'b1, 4'h0, 32'h0000_0000, rd);
      bus(1'b1, 4'h8, 32'h0000_1234, rd);
      rdc(4'h8, 32'h0000_0000);
      rdc(4'h6, 32'h0000_0000);
      bus(1'b1, 4'h0, 32'h0000_0001, rd);
      rdc(4'h8, {16'h0000, FLT[15:0]});
      complete_run();
   end
endmodule : eacr_regs_tb_top
